/* File: ssi_position_output.sv */
// Serial position output: word assembly, shifting and recovery time.
`include "ssi_position_defs.svh"

module ssi_position_output
    import ssi_position_pkg::*;
#(
    parameter int unsigned WORD_LEN  = `WORD_LEN_SHORT,
    parameter bit          GRAY_CODE = 1'b1,
    parameter int unsigned REC_CYC   = `RECOVERY_NS / `SYS_CLK_NS
) (
    // Clock and reset.
    input  wire logic                        sys_clk_i,
    input  wire logic                        resetn_i,
    // Link from the clock master.
    input  wire logic                        link_clk_i,
    output logic                             data_o,
    // Measurement results.
    input  wire logic [`POS_FIELD_MSB:0]     pos_value_i,
    input  wire logic [`POS_FIELD_MSB:0]     pos_limit_i,
    input  wire logic                        magnet_present_i,
    input  wire logic                        out_of_range_i,
    // Status.
    output logic                             busy_o
);
    localparam logic [`CNT_W-1:0] LAST_BIT = `CNT_W'(WORD_LEN);
    localparam logic [`REC_CNT_W-1:0] REC_LAST =
        `REC_CNT_W'(REC_CYC - 1);

    link_edge_if edges ();

    link_edge_detect u_edge (
        .sys_clk_i  (sys_clk_i),
        .resetn_i   (resetn_i),
        .link_clk_i (link_clk_i),
        .edges      (edges)
    );

    ssi_state_t                 state_r;
    ssi_state_t                 state_nxt;
    logic [WORD_LEN-1:0]        word_r;
    logic [`CNT_W-1:0]          bit_cnt_r;
    logic [`REC_CNT_W-1:0]      rec_cnt_r;
    logic                       data_r;

    // Word assembly from the current measurement.
    wire logic                       oor_flag;
    wire logic                       clamp_hit;
    wire logic [`POS_FIELD_MSB:0]    pos_sel;
    wire logic [`POS_FIELD_MSB:0]    pos_code;
    wire logic [WORD_LEN-1:0]        word_nxt;
    wire logic                       start;
    wire logic                       last_fall;
    wire logic                       rec_done;

    assign oor_flag  = out_of_range_i | ~magnet_present_i;
    assign clamp_hit = out_of_range_i & (pos_value_i > pos_limit_i);
    assign pos_sel   = !magnet_present_i ? '0 :
                       clamp_hit ? pos_limit_i : pos_value_i;
    assign pos_code  = GRAY_CODE ? (pos_sel ^ (pos_sel >> 1))
                                 : pos_sel;
    assign word_nxt  = WORD_LEN'({oor_flag, pos_code});

    assign start     = (state_r == ST_IDLE) & edges.fall;
    assign last_fall = (state_r == ST_SHIFT) & edges.fall
                       & (bit_cnt_r == LAST_BIT);
    assign rec_done  = (state_r == ST_RECOVER)
                       & (rec_cnt_r == REC_LAST);

    always_comb
    begin
        case (state_r)
            ST_IDLE:    state_nxt = start ? ST_SHIFT : ST_IDLE;
            ST_SHIFT:   state_nxt = last_fall ? ST_RECOVER : ST_SHIFT;
            ST_RECOVER: state_nxt = rec_done ? ST_IDLE : ST_RECOVER;
            default:    state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Shifting: the word is frozen at the first falling edge.
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            word_r    <= '0;
            bit_cnt_r <= '0;
        end
        else if (start)
        begin
            word_r    <= word_nxt;
            bit_cnt_r <= '0;
        end
        else if ((state_r == ST_SHIFT) && edges.rise
                 && (bit_cnt_r != LAST_BIT))
        begin
            word_r    <= word_r << 1;
            bit_cnt_r <= bit_cnt_r + 1'b1;
        end
    end

    // Recovery timer runs on the system clock only.
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            rec_cnt_r <= '0;
        else if (state_r == ST_RECOVER)
            rec_cnt_r <= rec_cnt_r + 1'b1;
        else
            rec_cnt_r <= '0;
    end

    // Data idles high, follows the word, and is held low in recovery.
    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
            data_r <= `DATA_IDLE;
        else if (last_fall)
            data_r <= `DATA_RECOVER;
        else if (rec_done)
            data_r <= `DATA_IDLE;
        else if ((state_r == ST_SHIFT) && edges.rise
                 && (bit_cnt_r != LAST_BIT))
            data_r <= word_r[WORD_LEN-1];
    end

    assign data_o = data_r;
    assign busy_o = (state_r != ST_IDLE);

    sequence s_last_fall;
        last_fall;
    endsequence

    sequence s_recovery_start;
        (state_r == ST_RECOVER) && (rec_cnt_r == '0) && !data_o;
    endsequence

    property p_enter_recovery;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        s_last_fall |=> s_recovery_start;
    endproperty

    AST_ENTER_RECOVERY: assert property (p_enter_recovery)
        else $error("recovery did not start after last falling edge");

    AST_RECOVERY_END: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        rec_done |=> (state_r == ST_IDLE) && data_o)
        else $error("recovery did not end at the set count");

    AST_RECOVERY_HOLD: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_r == ST_RECOVER) && !rec_done |=> (state_r == ST_RECOVER)
            && (rec_cnt_r == $past(rec_cnt_r) + 1'b1))
        else $error("recovery left early or counter stalled");

    AST_IDLE_ACCEPT: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_r == ST_IDLE) && edges.fall |=> (state_r == ST_SHIFT)
            && (word_r == $past(word_nxt)) && (bit_cnt_r == '0))
        else $error("read not accepted in idle");

    AST_MSB_FIRST: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_r == ST_SHIFT) && edges.rise && (bit_cnt_r != LAST_BIT)
        |=> data_o == $past(word_r[WORD_LEN-1]))
        else $error("bit shifted out of order");

    AST_BIT_LIMIT: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        bit_cnt_r <= LAST_BIT)
        else $error("more bits shifted than the word holds");

    AST_FLAG_BIT: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        word_nxt[`OOR_BIT] == (out_of_range_i || !magnet_present_i))
        else $error("out-of-range flag misplaced");

    AST_NO_MAGNET: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !magnet_present_i |-> word_nxt[`POS_FIELD_MSB:0] == '0)
        else $error("position not zero without magnet");

    AST_CLAMP: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        magnet_present_i && out_of_range_i |-> pos_sel <= pos_limit_i
            || pos_value_i <= pos_limit_i)
        else $error("position not limited beyond range");

    // Folds the coded field back to binary so the coding is checked apart.
    wire logic [`POS_FIELD_MSB:0]    pos_check;

    for (genvar gi = 0; gi < `POS_FIELD_W; gi++)
    begin : g_gray_decode
        assign pos_check[gi] = ^(pos_code >> gi);
    end

    AST_GRAY: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (GRAY_CODE ? pos_check : pos_code) == pos_sel)
        else $error("position field not in the build's code");

    AST_IDLE_HIGH: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_r == ST_IDLE) |-> data_o)
        else $error("data not high while idle");

    AST_RECOVERY_LOW: assert property (
        @(posedge sys_clk_i) disable iff (!resetn_i)
        (state_r == ST_RECOVER) |-> !data_o)
        else $error("data not low during recovery");
endmodule

/* File: ssi_position_defs.svh */
// Constants for the serial position output: word layout and timing.
`ifndef SSI_POSITION_DEFS_SVH
`define SSI_POSITION_DEFS_SVH

`define POS_FIELD_W     21
`define POS_FIELD_MSB   20
`define OOR_BIT         21
`define WORD_LEN_SHORT  24
`define WORD_LEN_LONG   25
`define CNT_W           5
`define SYS_CLK_NS      4
`define RECOVERY_NS     31000
`define REC_CNT_W       13
`define DATA_IDLE       1'b1
`define DATA_RECOVER    1'b0

`endif

/* File: ssi_position_pkg.sv */
// Types shared by the serial position output modules.
package ssi_position_pkg;
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SHIFT   = 2'b01,
        ST_RECOVER = 2'b10
    } ssi_state_t;
endpackage

/* File: link_edge_if.sv */
// Edge events of the synchronised link clock, passed between modules.
interface link_edge_if;
    logic rise;
    logic fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface

/* File: link_edge_detect.sv */
// Synchronises the master's link clock and reports its edges.
module link_edge_detect (
    // Clock and reset.
    input  wire logic   sys_clk_i,
    input  wire logic   resetn_i,
    // Link clock from the master.
    input  wire logic   link_clk_i,
    // Edge events.
    link_edge_if.src    edges
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r  <= 1'b1;
        end
        else
        begin
            sync1_r <= link_clk_i;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign edges.rise = sync2_r & ~prev_r;
    assign edges.fall = ~sync2_r & prev_r;
endmodule

/* File: ssi_master.sv */
// Clock master model that reads two serial position links at once.
module ssi_master (
    // Pacing clock.
    input  wire logic sys_clk_i,
    // Link clock and data lines.
    output logic      link_clk_o,
    input  wire logic data_a_i,
    input  wire logic data_b_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // The link clock stands high between frames.
    initial link_clk_o = 1'b1;

    task automatic half(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    // Sends 25 pulses; the 24-bit end ignores the last one.
    task automatic read(input int hp, output logic [24:0] wa,
                        output logic [24:0] wb);
        link_clk_o = 1'b0;
        for (int k = 0; k < 25; k++)
        begin
            half(hp);
            link_clk_o = 1'b1;
            half(hp);
            link_clk_o = 1'b0;
            wa = {wa[23:0], data_a_i};
            wb = {wb[23:0], data_b_i};
        end
        half(hp);
        link_clk_o = 1'b1;
    endtask

    // Starts a frame too early, inside the recovery time.
    task automatic pulse();
        half(10);
        link_clk_o = 1'b0;
        half(10);
        link_clk_o = 1'b1;
    endtask
endmodule

/* File: testbench.sv */
// Self-checking bench for the serial position output, two build variants.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REC = 100;
    logic        clk, rst_n, lclk, mag, oor, da, db, ba, bb;
    logic [20:0] pos, lim;
    logic [24:0] wa, wb;
    int          n_errors = 0;
    int          check_count = 0;

    ssi_position_output #(.WORD_LEN(24), .GRAY_CODE(1'b1), .REC_CYC(REC))
    i_dut (.sys_clk_i(clk), .resetn_i(rst_n), .link_clk_i(lclk),
        .data_o(da), .pos_value_i(pos), .pos_limit_i(lim),
        .magnet_present_i(mag), .out_of_range_i(oor), .busy_o(ba));
    ssi_position_output #(.WORD_LEN(25), .GRAY_CODE(1'b0), .REC_CYC(REC))
    i_dut_b (.sys_clk_i(clk), .resetn_i(rst_n), .link_clk_i(lclk),
        .data_o(db), .pos_value_i(pos), .pos_limit_i(lim),
        .magnet_present_i(mag), .out_of_range_i(oor), .busy_o(bb));
    ssi_master i_master (.sys_clk_i(clk), .link_clk_o(lclk),
        .data_a_i(da), .data_b_i(db));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [24:0] got, input logic [24:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    function automatic logic [24:0] exp_word(input logic gray);
        logic [20:0] p;
        p = (oor && pos > lim) ? lim : pos;
        p = mag ? p : 21'h0;
        p = gray ? (p ^ (p >> 1)) : p;
        return {3'h0, ~mag | oor, p};
    endfunction

    // Reads one frame, then measures the low recovery time on both ends.
    task automatic t_frame(input logic [20:0] p, input logic [20:0] l,
                           input logic m, input logic o, input int hp);
        int na;
        int nb;
        @(negedge clk);
        pos = p;
        lim = l;
        mag = m;
        oor = o;
        i_master.read(hp, wa, wb);
        check({1'b0, wa[24:1]}, exp_word(1'b1));
        check(wb, exp_word(1'b0));
        check(25'(wa[0]), 25'h0);
        na = 0;
        nb = 0;
        repeat (200)
        begin
            @(negedge clk);
            na += int'(da === 1'b0);
            nb += int'(db === 1'b0);
        end
        // Data goes low 2.5 clocks after the last fall, for REC clocks.
        check(25'(na), 25'(REC + 2 - 3 * hp));
        check(25'(nb), 25'(REC + 2 - hp));
        check({21'h0, ba, bb, da, db}, 25'h3);
        $display("frame test done at %0t", $time);
    endtask

    // A frame started inside recovery is ignored; the next one is whole.
    task automatic t_refuse();
        @(negedge clk);
        i_master.read(10, wa, wb);
        i_master.pulse();
        check({21'h0, ba, bb, da, db}, 25'hc);
        repeat (200) @(negedge clk);
        check({21'h0, ba, bb, da, db}, 25'h3);
        $display("refuse test done at %0t", $time);
        t_frame(21'h0_5a5a, 21'h1f_0000, 1'b1, 1'b0, 10);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_errors++;
        summarize();
    end

    initial
    begin
        rst_n = 1'b0;
        pos = 21'h0;
        lim = 21'h0;
        mag = 1'b1;
        oor = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check({21'h0, ba, bb, da, db}, 25'h3);
        t_frame(21'h1_2345, 21'h1f_ffff, 1'b1, 1'b0, 10);
        t_frame(21'h1f_fff0, 21'h1f_0000, 1'b1, 1'b1, 10);
        t_frame(21'h0_0100, 21'h1f_0000, 1'b1, 1'b1, 25);
        t_frame(21'h1f_ffff, 21'h1f_ffff, 1'b1, 1'b0, 25);
        t_frame(21'h0_abcd, 21'h1f_0000, 1'b0, 1'b0, 10);
        t_refuse();
        summarize();
    end
endmodule
